// file: verilog/dbio_consts.svh
`ifndef DBIO_CONSTS_SVH
`define DBIO_CONSTS_SVH

// Register byte addresses
`define DBIO_LOW_DATA_ADDR 12'h000
`define DBIO_LOW_DIR_ADDR 12'h004
`define DBIO_HIGH_DATA_ADDR 12'h008
`define DBIO_HIGH_DIR_ADDR 12'h00c
`define DBIO_MODE_ADDR 12'h010
`define DBIO_BUS_ADDR 12'h014
`define DBIO_BUS_DOUT_ADDR 12'h018
`define DBIO_BUS_DIN_ADDR 12'h01c

// Reset values: latch clear, every pin an input
`define DBIO_LATCH_RESET 8'h00
`define DBIO_DIR_RESET 8'hff
`define DBIO_MODE_RESET 2'h0
`define DBIO_MODE_W 2

// Mode codes
`define DBIO_MODE_MICROCTL 2'h0
`define DBIO_MODE_PROTECT 2'h1
`define DBIO_MODE_EXTCTL 2'h2
`define DBIO_MODE_MICROPROC 2'h3

// Bus control register fields
`define DBIO_BUS_DRIVE_BIT 0

// AXI responses
`define DBIO_RESP_OKAY 2'h0
`define DBIO_RESP_SLVERR 2'h2

`endif

// file: verilog/dbio_pkg.sv
package dbio_pkg;
    typedef enum logic [1:0] {
        DBIO_MICROCTL,
        DBIO_PROTECT,
        DBIO_EXTCTL,
        DBIO_MICROPROC
    } dbio_mode_t;
endpackage

// file: verilog/dbio_pin_byte.sv
`timescale 1ns/1ps
`include "dbio_consts.svh"

// One 8-pin port: latch, direction, pin steering and bus override
module dbio_pin_byte #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic latch_we_in,
    input wire logic dir_we_in,
    input wire logic [WIDTH-1:0] wdata_in,
    input wire logic bus_mode_in,
    input wire logic bus_drive_in,
    input wire logic [WIDTH-1:0] bus_dout_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n_out,
    output logic [WIDTH-1:0] latch_out,
    output logic [WIDTH-1:0] dir_out,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] latch_reg;
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] pin_reg;
    logic [WIDTH-1:0] oe_n_reg;
    wire logic [WIDTH-1:0] pin_next;
    wire logic [WIDTH-1:0] oe_n_next;

    if (WIDTH != 8) begin : g_width_check
        $error("dbio_pin_byte serves 8-pin ports only");
    end

    // Bus takes the pins over, otherwise latch drives pins with dir 0
    assign pin_next = bus_mode_in ? bus_dout_in : latch_reg;
    assign oe_n_next = bus_mode_in ? {WIDTH{~bus_drive_in}} :
        dir_reg;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            latch_reg <= `DBIO_LATCH_RESET;
            dir_reg <= `DBIO_DIR_RESET;
        end else begin
            // Latch holds its value whatever the direction
            if (latch_we_in) begin
                latch_reg <= wdata_in;
            end
            if (dir_we_in) begin
                dir_reg <= wdata_in;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            level_reg <= `DBIO_LATCH_RESET;
            pin_reg <= `DBIO_LATCH_RESET;
            oe_n_reg <= `DBIO_DIR_RESET;
        end else begin
            level_reg <= pin_in;
            pin_reg <= pin_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign pin_out = pin_reg;
    assign pin_oe_n_out = oe_n_reg;
    assign latch_out = latch_reg;
    assign dir_out = dir_reg;
    assign level_out = level_reg;
endmodule

// file: verilog/dbio_port.sv
`timescale 1ns/1ps
`include "dbio_consts.svh"

// Operation
// - Low port: eight pins, per-pin direction
// - Low direction one input, zero output
// - High port: its own eight pins, direction
// - Low data read pins, write latch
// - High data read pins, write latch
// - Bus mode: low port carries low byte
// - Bus mode: high port carries high byte
// - Processor or extended mode selects bus
// - Other two modes: plain general I/O
module dbio_port
    import dbio_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] low_port_pins_in,
    output logic [7:0] low_port_pins_out,
    output logic [7:0] low_port_pins_oe_n_out,
    input wire logic [7:0] high_port_pins_in,
    output logic [7:0] high_port_pins_out,
    output logic [7:0] high_port_pins_oe_n_out,
    output logic bus_active_out
);
    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    dbio_mode_t mode_reg;
    logic drive_reg;
    logic [15:0] bus_dout_reg;

    wire logic [7:0] low_latch;
    wire logic [7:0] low_dir;
    wire logic [7:0] low_level;
    wire logic [7:0] high_latch;
    wire logic [7:0] high_dir;
    wire logic [7:0] high_level;

    // Register selection codes
    localparam logic [2:0] SEL_LOW_DATA = 3'h0;
    localparam logic [2:0] SEL_LOW_DIR = 3'h1;
    localparam logic [2:0] SEL_HIGH_DATA = 3'h2;
    localparam logic [2:0] SEL_HIGH_DIR = 3'h3;
    localparam logic [2:0] SEL_MODE = 3'h4;
    localparam logic [2:0] SEL_BUS_CTL = 3'h5;
    localparam logic [2:0] SEL_BUS_DOUT = 3'h6;
    localparam logic [2:0] SEL_BUS_DIN = 3'h7;

    // Wider addresses would alias onto the register map
    if (ADDR_W < 5 || ADDR_W > 12) begin : g_addr_check
        $error("dbio_port serves 5 to 12 address bits");
    end

    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [11:0] w;
        w = 12'(a);
        if (w == `DBIO_LOW_DATA_ADDR) begin
            reg_sel = SEL_LOW_DATA;
        end else if (w == `DBIO_LOW_DIR_ADDR) begin
            reg_sel = SEL_LOW_DIR;
        end else if (w == `DBIO_HIGH_DATA_ADDR) begin
            reg_sel = SEL_HIGH_DATA;
        end else if (w == `DBIO_HIGH_DIR_ADDR) begin
            reg_sel = SEL_HIGH_DIR;
        end else if (w == `DBIO_MODE_ADDR) begin
            reg_sel = SEL_MODE;
        end else if (w == `DBIO_BUS_ADDR) begin
            reg_sel = SEL_BUS_CTL;
        end else if (w == `DBIO_BUS_DOUT_ADDR) begin
            reg_sel = SEL_BUS_DOUT;
        end else if (w == `DBIO_BUS_DIN_ADDR) begin
            reg_sel = SEL_BUS_DIN;
        end else begin
            reg_sel = SEL_LOW_DATA;
        end
    endfunction

    // Only aligned words up to the last register answer
    function automatic logic hit(input logic [ADDR_W-1:0] a);
        logic [11:0] w;
        w = 12'(a);
        hit = (w <= `DBIO_BUS_DIN_ADDR) && (w[1:0] == 2'h0);
    endfunction

    // Write channel: address and data taken in either order
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;

    wire logic aw_have = aw_held_reg || aw_take;
    wire logic w_have = w_held_reg || w_take;
    wire logic [ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire logic [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire logic wr_do = aw_have && w_have && !bvalid_reg;
    wire logic wr_hit = hit(wr_addr);
    wire logic [2:0] wr_sel = reg_sel(wr_addr);
    wire logic wr_lane0 = wr_do && wr_hit && wr_strb[0];
    wire logic wr_lane1 = wr_do && wr_hit && wr_strb[1];

    wire logic low_latch_we = wr_lane0 && (wr_sel == SEL_LOW_DATA);
    wire logic low_dir_we = wr_lane0 && (wr_sel == SEL_LOW_DIR);
    wire logic high_latch_we = wr_lane0 && (wr_sel == SEL_HIGH_DATA);
    wire logic high_dir_we = wr_lane0 && (wr_sel == SEL_HIGH_DIR);
    wire logic mode_we = wr_lane0 && (wr_sel == SEL_MODE);
    wire logic ctl_we = wr_lane0 && (wr_sel == SEL_BUS_CTL);
    wire logic dout_lo_we = wr_lane0 && (wr_sel == SEL_BUS_DOUT);
    wire logic dout_hi_we = wr_lane1 && (wr_sel == SEL_BUS_DOUT);

    // Processor and extended modes hand the pins to the bus
    wire logic bus_mode = (mode_reg == DBIO_MICROPROC) ||
        (mode_reg == DBIO_EXTCTL);

    // Address held until its data arrives
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (wr_do) begin
            aw_held_reg <= 1'b0;
        end else if (aw_take) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end
    end

    // Data held until its address arrives
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (wr_do) begin
            w_held_reg <= 1'b0;
        end else if (w_take) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end
    end

    // Write response
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `DBIO_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `DBIO_RESP_OKAY : `DBIO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Operating mode
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_reg <= DBIO_MICROCTL;
        end else if (mode_we) begin
            mode_reg <= dbio_mode_t'(wr_data[`DBIO_MODE_W-1:0]);
        end
    end

    // Bus drive enable
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            drive_reg <= 1'b0;
        end else if (ctl_we) begin
            drive_reg <= wr_data[`DBIO_BUS_DRIVE_BIT];
        end
    end

    // Bus output data, one lane per byte strobe
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            bus_dout_reg <= '0;
        end else begin
            if (dout_lo_we) begin
                bus_dout_reg[7:0] <= wr_data[7:0];
            end
            if (dout_hi_we) begin
                bus_dout_reg[15:8] <= wr_data[15:8];
            end
        end
    end

    // Read channel
    assign s_axi_arready = !rvalid_reg;
    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    wire logic rd_hit = hit(s_axi_araddr);
    wire logic [2:0] rd_sel = reg_sel(s_axi_araddr);

    // Read data by register; unmapped addresses read zero
    function automatic logic [31:0] rd_mux(input logic [2:0] sel);
        if (sel == SEL_LOW_DATA) begin
            rd_mux = {24'h00_0000, low_level};
        end else if (sel == SEL_LOW_DIR) begin
            rd_mux = {24'h00_0000, low_dir};
        end else if (sel == SEL_HIGH_DATA) begin
            rd_mux = {24'h00_0000, high_level};
        end else if (sel == SEL_HIGH_DIR) begin
            rd_mux = {24'h00_0000, high_dir};
        end else if (sel == SEL_MODE) begin
            rd_mux = {30'h0, mode_reg};
        end else if (sel == SEL_BUS_CTL) begin
            rd_mux = {30'h0, bus_mode, drive_reg};
        end else if (sel == SEL_BUS_DOUT) begin
            rd_mux = {16'h0000, bus_dout_reg};
        end else begin
            rd_mux = {16'h0000, high_level, low_level};
        end
    endfunction

    wire logic [31:0] rd_word = rd_hit ? rd_mux(rd_sel) : 32'h0000_0000;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `DBIO_RESP_OKAY;
            rdata_reg <= '0;
        end else begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? `DBIO_RESP_OKAY : `DBIO_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign bus_active_out = bus_mode;

    dbio_pin_byte #(.WIDTH(8)) u_low (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .latch_we_in(low_latch_we),
        .dir_we_in(low_dir_we),
        .wdata_in(wr_data[7:0]),
        .bus_mode_in(bus_mode),
        .bus_drive_in(drive_reg),
        .bus_dout_in(bus_dout_reg[7:0]),
        .pin_in(low_port_pins_in),
        .pin_out(low_port_pins_out),
        .pin_oe_n_out(low_port_pins_oe_n_out),
        .latch_out(low_latch),
        .dir_out(low_dir),
        .level_out(low_level)
    );

    dbio_pin_byte #(.WIDTH(8)) u_high (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .latch_we_in(high_latch_we),
        .dir_we_in(high_dir_we),
        .wdata_in(wr_data[7:0]),
        .bus_mode_in(bus_mode),
        .bus_drive_in(drive_reg),
        .bus_dout_in(bus_dout_reg[15:8]),
        .pin_in(high_port_pins_in),
        .pin_out(high_port_pins_out),
        .pin_oe_n_out(high_port_pins_oe_n_out),
        .latch_out(high_latch),
        .dir_out(high_dir),
        .level_out(high_level)
    );
endmodule

// file: test/dbio_port_chk.sv
`timescale 1ns/1ps
module dbio_port_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] low_port_pins_oe_n_out,
    input wire logic [7:0] high_port_pins_oe_n_out,
    input wire logic bus_active_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_ar_rdy;
        s_axi_arready == !s_axi_rvalid;
    endproperty
    a_ar_rdy: assert property (p_ar_rdy) else $error("arready wrong");
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write not blocked");
    property p_bad_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h01c
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped read ok");
    property p_bus_pins;
        bus_active_out [*3] |-> low_port_pins_oe_n_out ==
            high_port_pins_oe_n_out && (low_port_pins_oe_n_out == 8'h00 ||
            low_port_pins_oe_n_out == 8'hff);
    endproperty
    a_bus_pins: assert property (p_bus_pins)
        else $error("bus pins split");
endmodule

bind dbio_port dbio_port_chk #(.ADDR_W(ADDR_W)) u_dbio_port_chk (.mclk_in,
    .reset_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .low_port_pins_oe_n_out,
    .high_port_pins_oe_n_out, .bus_active_out);

// file: test/dbio_pin_model.sv
`timescale 1ns/1ps
module dbio_pin_model (
    input wire logic [7:0] pins_out_in,
    input wire logic [7:0] oe_n_in,
    input wire logic [7:0] ext_in,
    output logic [7:0] pins_in_out
);
    // Released pins follow the outside driver
    assign pins_in_out = (oe_n_in & ext_in) |
        (~oe_n_in & pins_out_in);
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, bus_active_out;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] low_port_pins_in, low_port_pins_out, low_port_pins_oe_n_out;
    logic [7:0] high_port_pins_in, high_port_pins_out, high_port_pins_oe_n_out;
    logic [7:0] ext_low = 8'ha5, ext_high = 8'h96;
    int n_errors = 0, samples_checked = 0;
    always #2.5 mclk_in = ~mclk_in;
    dbio_port u_dbio_port (.mclk_in, .reset_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_port_pins_in,
        .low_port_pins_out, .low_port_pins_oe_n_out, .high_port_pins_in,
        .high_port_pins_out, .high_port_pins_oe_n_out, .bus_active_out);
    dbio_pin_model u_dbio_pin_model (.pins_out_in(low_port_pins_out),
        .oe_n_in(low_port_pins_oe_n_out), .ext_in(ext_low),
        .pins_in_out(low_port_pins_in));
    dbio_pin_model u_dbio_pin_model_hi (.pins_out_in(high_port_pins_out),
        .oe_n_in(high_port_pins_oe_n_out), .ext_in(ext_high),
        .pins_in_out(high_port_pins_in));
    task automatic conclude;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        @(posedge mclk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk_in);
    endtask
    function automatic logic [7:0] oe(input bit hi);
        return hi ? high_port_pins_oe_n_out : low_port_pins_oe_n_out;
    endfunction
    function automatic logic [7:0] po(input bit hi);
        return hi ? high_port_pins_out : low_port_pins_out;
    endfunction
    task automatic t_reset;
        rd_reg(12'h004);
        chk(rd, 32'hff);
        rd_reg(12'h00c);
        chk(rd, 32'hff);
        chk(low_port_pins_oe_n_out, 8'hff);
        chk(high_port_pins_oe_n_out, 8'hff);
        chk({high_port_pins_out, low_port_pins_out}, 16'h0000);
        chk(bus_active_out, 1'b0);
    endtask
    task automatic t_gpio(input logic [11:0] base, input bit hi);
        logic [7:0] ext;
        ext = hi ? ext_high : ext_low;
        wr(base, 32'h30);
        chk(resp, 2'h0);
        settle;
        chk(oe(hi), 8'hff);
        rd_reg(base);
        chk(rd, {24'h0, ext});
        wr(base + 12'h004, 32'hcf);
        settle;
        chk(oe(hi), 8'hcf);
        chk(po(hi) & 8'h30, 8'h30);
        rd_reg(base);
        chk(rd, {24'h0, (ext & 8'hcf) | 8'h30});
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(12'h010, 32'(m));
            wr(12'h014, 32'h1);
            wr(12'h018, 32'h5a3c);
            settle;
            chk(bus_active_out, 1'(m >= 2));
            if (m >= 2) begin
                chk(low_port_pins_out, 8'h3c);
                chk(high_port_pins_out, 8'h5a);
                chk(low_port_pins_oe_n_out, 8'h00);
                chk(high_port_pins_oe_n_out, 8'h00);
            end else begin
                chk(low_port_pins_oe_n_out, 8'hcf);
            end
        end
        rd_reg(12'h010);
        chk(rd, 32'h3);
        rd_reg(12'h014);
        chk(rd, 32'h3);
        s_axi_wstrb <= 4'h2;
        wr(12'h018, 32'h11ff);
        s_axi_wstrb <= 4'hf;
        settle;
        chk(high_port_pins_out, 8'h11);
        chk(low_port_pins_out, 8'h3c);
        rd_reg(12'h018);
        chk(rd, 32'h113c);
        wr(12'h004, 32'h0f);
        wr(12'h014, 32'h0);
        settle;
        rd_reg(12'h01c);
        chk(rd[15:0], {ext_high, ext_low});
        wr(12'h010, 32'h0);
        settle;
        chk(low_port_pins_oe_n_out, 8'h0f);
        chk(low_port_pins_out, 8'h30);
    endtask
    task automatic t_bad;
        wr(12'h020, 32'h1);
        chk(resp, 2'h2);
        rd_reg(12'h021);
        chk(resp, 2'h2);
        chk(rd, 32'h0);
    endtask
    task automatic t_rerun;
        reset_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_reset;
    endtask
    initial begin
        repeat (16) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_reset;
        t_gpio(12'h000, 1'b0);
        t_gpio(12'h008, 1'b1);
        t_modes;
        t_bad;
        t_rerun;
        conclude;
    end
    initial begin
        repeat (5000) @(posedge mclk_in);
        n_errors++;
        conclude;
    end
endmodule
